/* shared/mps_pkg.sv */
// constants and types for the program sequencer core
package mps_pkg;
   // register byte offsets on the avalon slave
   localparam logic [3:0] ADDR_PC_LOW = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   localparam logic [3:0] ADDR_PC = 4'hc;
   // control register fields and reset value
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_IEN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // status register fields
   localparam int STAT_FLAG_LSB = 0;
   localparam int STAT_ACC_LSB = 8;
   localparam int STAT_DEPTH_LSB = 16;
   localparam int STAT_FULL_BIT = 24;
   localparam int STAT_PEND_BIT = 25;
   // flag bit positions
   localparam int FLG_C = 0;
   localparam int FLG_AC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   // reset values
   localparam logic [11:0] RESET_VECTOR = 12'h000;
   localparam logic [15:0] NOP_WORD = 16'hf000;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET = 4'h0;

   typedef enum logic [3:0] {
      PH_T1 = 4'b0001,
      PH_T2 = 4'b0010,
      PH_T3 = 4'b0100,
      PH_T4 = 4'b1000
   } mps_phase_t;

   // instruction class in word bits 15:12
   typedef enum logic [3:0] {
      CL_ALU = 4'h0,
      CL_JUMP = 4'h1,
      CL_CALL = 4'h2,
      CL_RETURN = 4'h3,
      CL_SKIP_Z = 4'h4,
      CL_SKIP_NZ = 4'h5,
      CL_WR_PC_LOW = 4'h6,
      CL_RD_PC_LOW = 4'h7,
      CL_NOP = 4'hf
   } mps_class_t;

   // alu function in word bits 11:8, operand in bits 7:0
   typedef enum logic [3:0] {
      AF_ADD = 4'h0,
      AF_ADC = 4'h1,
      AF_SUB = 4'h2,
      AF_SBC = 4'h3,
      AF_AND = 4'h4,
      AF_OR = 4'h5,
      AF_XOR = 4'h6,
      AF_CPL = 4'h7,
      AF_RR = 4'h8,
      AF_RRC = 4'h9,
      AF_RL = 4'ha,
      AF_RLC = 4'hb,
      AF_INC = 4'hc,
      AF_DEC = 4'hd,
      AF_DAA = 4'he,
      AF_LOAD = 4'hf
   } mps_alu_t;
endpackage : mps_pkg

/* hw/mps_ret_stack.sv */
// return address memory with registered read port
module mps_ret_stack #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : mps_ret_stack

/* hw/mps_sequencer.sv */
// four-phase fetch/execute sequencer with return stack and alu
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
module mps_sequencer #(
   parameter int PC_WIDTH = 12,
   parameter int STACK_DEPTH = 8,
   parameter logic [11:0] INT_VECTOR = 12'h004
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [PC_WIDTH-1:0] imem_addr,
   input wire logic [15:0] imem_data,
   input wire logic int_request
);
   localparam int SPW = $clog2(STACK_DEPTH);

   if (PC_WIDTH != 11 && PC_WIDTH != 12) begin : g_width_chk
      $error("PC_WIDTH must be 11 or 12");
   end
   if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin : g_depth_chk
      $error("STACK_DEPTH must be a power of two >= 2");
   end

   // result {flags, value}
   function automatic logic [11:0] alu_eval(
      input logic [3:0] fn,
      input logic [7:0] a,
      input logic [7:0] b,
      input logic [3:0] fl
   );
      logic [8:0] wide;
      logic [4:0] half;
      logic [7:0] r;
      logic [3:0] f;
      logic arith;
      wide = 9'h000;
      half = 5'h00;
      r = a;
      f = fl;
      arith = 1'b0;
      case (mps_pkg::mps_alu_t'(fn))
         mps_pkg::AF_ADD, mps_pkg::AF_ADC: begin
            wide = {1'b0, a} + {1'b0, b} +
               {8'h00, fn[0] & fl[mps_pkg::FLG_C]};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} +
               {4'h0, fn[0] & fl[mps_pkg::FLG_C]};
            arith = 1'b1;
         end
         mps_pkg::AF_SUB, mps_pkg::AF_SBC: begin
            // carry set means no borrow
            wide = {1'b0, a} + {1'b0, ~b} +
               {8'h00, ~fn[0] | fl[mps_pkg::FLG_C]};
            half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} +
               {4'h0, ~fn[0] | fl[mps_pkg::FLG_C]};
            arith = 1'b1;
         end
         mps_pkg::AF_AND: r = a & b;
         mps_pkg::AF_OR: r = a | b;
         mps_pkg::AF_XOR: r = a ^ b;
         mps_pkg::AF_CPL: r = ~a;
         mps_pkg::AF_RR: r = {a[0], a[7:1]};
         mps_pkg::AF_RL: r = {a[6:0], a[7]};
         mps_pkg::AF_RRC: begin
            r = {fl[mps_pkg::FLG_C], a[7:1]};
            f[mps_pkg::FLG_C] = a[0];
         end
         mps_pkg::AF_RLC: begin
            r = {a[6:0], fl[mps_pkg::FLG_C]};
            f[mps_pkg::FLG_C] = a[7];
         end
         mps_pkg::AF_INC: r = a + 8'h01;
         mps_pkg::AF_DEC: r = a - 8'h01;
         mps_pkg::AF_DAA: begin
            wide = {1'b0, a};
            if (a[3:0] > 4'h9 || fl[mps_pkg::FLG_AC]) begin
               wide = wide + 9'h006;
            end
            if (wide[7:4] > 4'h9 || fl[mps_pkg::FLG_C] || wide[8]) begin
               wide = wide + 9'h060;
            end
            r = wide[7:0];
            f[mps_pkg::FLG_C] = wide[8] | fl[mps_pkg::FLG_C];
         end
         default: r = b;
      endcase
      if (arith) begin
         r = wide[7:0];
         f[mps_pkg::FLG_C] = wide[8];
         f[mps_pkg::FLG_AC] = half[4];
         f[mps_pkg::FLG_OV] = (a[7] == (fn[1] ? ~b[7] : b[7])) &&
            (r[7] != a[7]);
      end
      f[mps_pkg::FLG_Z] = (r == 8'h00);
      return {f, r};
   endfunction : alu_eval

   mps_pkg::mps_phase_t phase, next_phase;
   logic [PC_WIDTH-1:0] pc, next_pc;
   logic [PC_WIDTH-1:0] next_imem_addr;
   logic [15:0] ir, next_ir;
   logic [7:0] acc, next_acc;
   logic [3:0] flags, next_flags;
   logic [1:0] ctrl, next_ctrl;
   logic int_pend, next_int_pend;
   logic [SPW:0] depth, next_depth;
   logic [SPW-1:0] top, next_top;
   logic low_req, next_low_req;
   logic [7:0] low_val, next_low_val;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic int_meta, int_sync;
   logic push;
   logic [PC_WIDTH-1:0] push_data;
   logic [PC_WIDTH-1:0] pop_data;
   logic [11:0] alu_out;
   logic flush;
   logic stack_full;
   logic [SPW-1:0] pop_addr;
   logic bus_low_wr;
   logic bus_ctrl_wr;

   mps_ret_stack #(
      .WIDTH(PC_WIDTH),
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .clock(clock),
      .wr_en(push),
      .wr_addr(top),
      .wr_data(push_data),
      .rd_addr(pop_addr),
      .rd_data(pop_data)
   );

   // pin crossing, only the second stage is read
   always_ff @(posedge clock) begin
      int_meta <= int_request;
      int_sync <= int_meta;
   end

   assign stack_full = (depth == (SPW+1)'(STACK_DEPTH));
   assign pop_addr = top - SPW'(1);
   assign alu_out = alu_eval(ir[11:8], acc, ir[7:0], flags);

   // a bus write is taken only in the cycle waitrequest is low
   assign bus_low_wr = avs_write && !avs_waitrequest &&
      avs_address == mps_pkg::ADDR_PC_LOW;
   assign bus_ctrl_wr = avs_write && !avs_waitrequest &&
      avs_address == mps_pkg::ADDR_CTRL;

   // core sequencing
   always_comb begin
      next_phase = phase;
      next_pc = pc;
      next_imem_addr = imem_addr;
      next_ir = ir;
      next_acc = acc;
      next_flags = flags;
      next_ctrl = ctrl;
      next_depth = depth;
      next_top = top;
      next_low_req = low_req;
      next_low_val = low_val;
      next_int_pend = int_pend;
      push = 1'b0;
      push_data = imem_addr;
      flush = 1'b0;
      if (ctrl[mps_pkg::CTRL_RUN_BIT]) begin
         case (phase)
            mps_pkg::PH_T1: begin
               next_imem_addr = pc;
               next_pc = pc + 1'b1;
               next_phase = mps_pkg::PH_T2;
            end
            mps_pkg::PH_T2: next_phase = mps_pkg::PH_T3;
            mps_pkg::PH_T3: next_phase = mps_pkg::PH_T4;
            default: begin
               next_phase = mps_pkg::PH_T1;
               case (mps_pkg::mps_class_t'(ir[15:12]))
                  mps_pkg::CL_ALU: begin
                     next_acc = alu_out[7:0];
                     next_flags = alu_out[11:8];
                  end
                  mps_pkg::CL_JUMP: begin
                     next_pc = ir[PC_WIDTH-1:0];
                     flush = 1'b1;
                  end
                  mps_pkg::CL_CALL: begin
                     // return lands on the discarded prefetch
                     push = 1'b1;
                     next_top = top + 1'b1;
                     if (!stack_full) begin
                        next_depth = depth + 1'b1;
                     end
                     next_pc = ir[PC_WIDTH-1:0];
                     flush = 1'b1;
                  end
                  mps_pkg::CL_RETURN: begin
                     // empty stack still reloads; depth stays zero
                     next_pc = pop_data;
                     next_top = top - 1'b1;
                     if (depth != '0) begin
                        next_depth = depth - 1'b1;
                     end
                     if (ir[0]) begin
                        next_ctrl[mps_pkg::CTRL_IEN_BIT] = 1'b1;
                     end
                     flush = 1'b1;
                  end
                  mps_pkg::CL_SKIP_Z: flush = (acc == 8'h00);
                  mps_pkg::CL_SKIP_NZ: flush = (acc != 8'h00);
                  mps_pkg::CL_WR_PC_LOW: begin
                     next_pc[7:0] = acc;
                     flush = 1'b1;
                  end
                  mps_pkg::CL_RD_PC_LOW: next_acc = pc[7:0];
                  default: ;
               endcase
               if (low_req) begin
                  next_pc[7:0] = low_val;
                  next_low_req = 1'b0;
                  flush = 1'b1;
               end else if (int_pend && ctrl[mps_pkg::CTRL_IEN_BIT] &&
                  !stack_full && !flush) begin
                  // acknowledge waits on a full stack
                  push = 1'b1;
                  next_top = top + 1'b1;
                  next_depth = depth + 1'b1;
                  next_pc = INT_VECTOR[PC_WIDTH-1:0];
                  next_ctrl[mps_pkg::CTRL_IEN_BIT] = 1'b0;
                  next_int_pend = 1'b0;
                  flush = 1'b1;
               end
               next_ir = flush ? mps_pkg::NOP_WORD : imem_data;
            end
         endcase
      end
      if (bus_ctrl_wr) begin
         next_ctrl = avs_writedata[1:0];
      end
      if (bus_low_wr) begin
         next_low_req = 1'b1;
         next_low_val = avs_writedata[7:0];
      end
      if (int_sync) begin
         next_int_pend = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         phase <= mps_pkg::PH_T1;
         pc <= mps_pkg::RESET_VECTOR[PC_WIDTH-1:0];
         imem_addr <= mps_pkg::RESET_VECTOR[PC_WIDTH-1:0];
         ir <= mps_pkg::NOP_WORD;
         acc <= mps_pkg::ACC_RESET;
         flags <= mps_pkg::FLAGS_RESET;
         ctrl <= mps_pkg::CTRL_RESET;
         depth <= '0;
         top <= '0;
         low_req <= 1'b0;
         low_val <= 8'h00;
         int_pend <= 1'b0;
      end else begin
         phase <= next_phase;
         pc <= next_pc;
         imem_addr <= next_imem_addr;
         ir <= next_ir;
         acc <= next_acc;
         flags <= next_flags;
         ctrl <= next_ctrl;
         depth <= next_depth;
         top <= next_top;
         low_req <= next_low_req;
         low_val <= next_low_val;
         int_pend <= next_int_pend;
      end
   end

   // avalon slave: one wait cycle, then answer
   always_comb begin
      next_waitrequest = 1'b1;
      next_readdata = avs_readdata;
      if ((avs_read || avs_write) && avs_waitrequest) begin
         next_waitrequest = 1'b0;
         next_readdata = 32'h00000000;
         if (avs_address == mps_pkg::ADDR_PC_LOW) begin
            next_readdata[7:0] = pc[7:0];
         end else if (avs_address == mps_pkg::ADDR_CTRL) begin
            next_readdata[1:0] = ctrl;
         end else if (avs_address == mps_pkg::ADDR_STAT) begin
            // stack contents stay hidden, only its fill shows
            next_readdata[mps_pkg::STAT_FLAG_LSB +: 4] = flags;
            next_readdata[mps_pkg::STAT_ACC_LSB +: 8] = acc;
            next_readdata[mps_pkg::STAT_DEPTH_LSB +: SPW+1] = depth;
            next_readdata[mps_pkg::STAT_FULL_BIT] = stack_full;
            next_readdata[mps_pkg::STAT_PEND_BIT] = int_pend;
         end else if (avs_address == mps_pkg::ADDR_PC) begin
            next_readdata[PC_WIDTH-1:0] = pc;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
      end
   end
endmodule : mps_sequencer

/* tb/mps_sequencer_assertions.sv */
// port-level checker for the program sequencer
module mps_sequencer_assertions #(
   parameter int PC_WIDTH = 12
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [PC_WIDTH-1:0] imem_addr,
   input wire logic [15:0] imem_data,
   input wire logic int_request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [PC_WIDTH-1:0] low_target;
   logic [PC_WIDTH-1:0] next_low_target;
   logic low_wr;
   assign low_wr = avs_write && !avs_waitrequest
      && avs_address == mps_pkg::ADDR_PC_LOW;
   // page comes from the fetch address, fine away from page edges
   always_comb begin
      next_low_target = low_target;
      if (low_wr) begin
         next_low_target = {imem_addr[PC_WIDTH-1:8], avs_writedata[7:0]};
      end
   end
   always_ff @(posedge clock) begin
      low_target <= next_low_target;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // fetch of a word, then its sequential prefetch, no bus write or irq
   sequence s_fetch(ok);
      $changed(imem_addr) ##2 ok ##2 ($changed(imem_addr)
         && imem_addr == $past(imem_addr, 4) + 1'b1)
         ##1 (!avs_write && !int_request)[*3];
   endsequence
   property p_rst_vector;
      $fell(sys_rst) |-> imem_addr == '0 && avs_waitrequest;
   endproperty
   property p_fetch_hold;
      $changed(imem_addr) |=> $stable(imem_addr)[*3];
   endproperty
   property p_seq_advance;
      s_fetch(imem_data[15:12] == 4'h0)
         |=> imem_addr == $past(imem_addr, 4) + 1'b1;
   endproperty
   property p_branch_target;
      s_fetch(imem_data[15:12] inside {4'h1, 4'h2})
         |=> imem_addr == $past(imem_data[PC_WIDTH-1:0], 6);
   endproperty
   property p_bus_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_bus_release;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_low_upper_zero;
      avs_read && !avs_waitrequest && avs_address == mps_pkg::ADDR_PC_LOW
         |-> avs_readdata[31:8] == '0;
   endproperty
   property p_unmapped_zero;
      avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
         |-> avs_readdata == '0;
   endproperty
   property p_low_write_page;
      low_wr |=> ##[0:8] imem_addr == low_target;
   endproperty
   a_rst_vector: assert property (p_rst_vector)
      else $error("fetch not at zero after reset");
   a_fetch_hold: assert property (p_fetch_hold)
      else $error("fetch address held under four cycles");
   a_seq_advance: assert property (p_seq_advance)
      else $error("plain instruction did not advance by one");
   a_branch_target: assert property (p_branch_target)
      else $error("branch target not fetched after one cycle");
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus request not answered next cycle");
   a_bus_release: assert property (p_bus_release)
      else $error("waitrequest low for more than one cycle");
   a_low_upper_zero: assert property (p_low_upper_zero)
      else $error("low byte read shows upper bits");
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");
   a_low_write_page: assert property (p_low_write_page)
      else $error("low byte write did not jump in page");
endmodule : mps_sequencer_assertions

bind mps_sequencer mps_sequencer_assertions #(.PC_WIDTH(PC_WIDTH)) chk_i (
   .clock(clock),
   .sys_rst(sys_rst),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .imem_addr(imem_addr),
   .imem_data(imem_data),
   .int_request(int_request)
);

/* tb/mps_prog_mem.sv */
// program memory model with a one or two cycle read path
module mps_prog_mem #(
   parameter int PC_WIDTH = 12,
   parameter int LAT = 1
) (
   input wire logic clock,
   input wire logic [PC_WIDTH-1:0] addr,
   output logic [15:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [2**PC_WIDTH];
   logic [15:0] d1;
   logic [15:0] d2;
   // two stages is the slowest read the fetch timing tolerates
   always_ff @(posedge clock) begin
      d1 <= mem[addr];
      d2 <= d1;
   end
   assign data = (LAT == 2) ? d2 : d1;
endmodule : mps_prog_mem

/* tb/mps_sequencer_tb.sv */
// self-checking bench for the program sequencer
module mps_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ALU_EXP [16] = '{8'hd1, 8'hd1, 8'h67, 8'h66,
      8'h14, 8'hbd, 8'ha9, 8'h63, 8'h4e, 8'h4e, 8'h39, 8'h38, 8'h9d,
      8'h9b, 8'h02, 8'h35};
   localparam logic [11:0] TRACE [16] = '{12'h000, 12'h001, 12'h002,
      12'h003, 12'h010, 12'h011, 12'h020, 12'h021, 12'h022, 12'h011,
      12'h012, 12'h013, 12'h014, 12'h015, 12'h030, 12'h031};
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [11:0] imem_addr;
   logic [15:0] imem_data;
   logic int_request = 1'b0;
   logic [31:0] q;
   logic [11:0] flog [$];
   int n_mismatch = 0;
   int n_checks = 0;

   always #2 clock = ~clock;

   mps_sequencer #(.PC_WIDTH(12), .STACK_DEPTH(2)) uut (
      .clock(clock),
      .sys_rst(sys_rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .imem_addr(imem_addr),
      .imem_data(imem_data),
      .int_request(int_request)
   );
   mps_prog_mem #(.PC_WIDTH(12), .LAT(2)) mem_i (
      .clock(clock),
      .addr(imem_addr),
      .data(imem_data)
   );

   // fetch address changes since the last reset
   always @(posedge clock) begin
      if (sys_rst) begin
         flog.delete();
      end else if (flog.size() == 0 || imem_addr !== flog[$]) begin
         flog.push_back(imem_addr);
      end
   end

   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // load a program of {address, word} pairs, reset, let it run
   task automatic run(input logic [27:0] p [$], input int n);
      foreach (mem_i.mem[i]) mem_i.mem[i] = mps_pkg::NOP_WORD;
      foreach (p[i]) mem_i.mem[p[i][27:16]] = p[i][15:0];
      sys_rst <= 1'b1;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (n) @(posedge clock);
   endtask : run

   function automatic logic seen(input logic [11:0] a);
      foreach (flog[i]) begin
         if (flog[i] === a) return 1'b1;
      end
      return 1'b0;
   endfunction : seen

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // all tests need about 1200 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      close_out();
   end

   initial begin
      run('{28'h000_0f05, 28'h001_0003, 28'h002_1010, 28'h003_0f99,
         28'h010_2020, 28'h011_4000, 28'h012_0f77, 28'h013_0f30,
         28'h014_6000, 28'h015_0f55, 28'h020_0f00, 28'h021_3000,
         28'h022_0f66, 28'h030_1030}, 100);
      for (int i = 0; i < 16; i++) begin
         chk("fetch", 32'(flog[i]), 32'(TRACE[i]));
      end
      bus(1'b0, mps_pkg::ADDR_STAT, 32'h0);
      chk("acc", q[15:8], 8'h30);
      chk("depth", q[17:16], 2'h0);
      bus(1'b0, mps_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl", q, 32'(mps_pkg::CTRL_RESET));
      bus(1'b1, 4'h6, 32'hff);
      bus(1'b0, 4'h6, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1'b0, mps_pkg::ADDR_PC_LOW, 32'h0);
      chk("low byte high", q[31:8], 24'h0);
      $display("test trace done");
      for (int f = 0; f < 16; f++) begin
         run('{28'h000_0f9c, {12'h001, 4'h0, 4'(f), 8'h35},
            28'h002_1002}, 40);
         bus(1'b0, mps_pkg::ADDR_STAT, 32'h0);
         chk("alu acc", q[15:8], ALU_EXP[f]);
         chk("depth", q[17:16], 2'h0);
         if (f < 4) chk("carry", q[0], f > 1);
      end
      $display("test alu done");
      // skip on nonzero, low byte read, then an interrupt return
      run('{28'h000_1010, 28'h004_3001, 28'h010_7000, 28'h011_5000,
         28'h012_0f11, 28'h013_1013}, 40);
      bus(1'b0, mps_pkg::ADDR_STAT, 32'h0);
      chk("low byte read", q[15:8], 8'h12);
      bus(1'b0, mps_pkg::ADDR_PC, 32'h0);
      chk("pc page", q[31:4], 28'h0000001);
      bus(1'b1, mps_pkg::ADDR_CTRL, 32'h3);
      int_request <= 1'b1;
      repeat (3) @(posedge clock);
      int_request <= 1'b0;
      repeat (60) @(posedge clock);
      chk("vector", seen(12'h004), 1'b1);
      bus(1'b0, mps_pkg::ADDR_CTRL, 32'h0);
      chk("ien back", q[1:0], 2'h3);
      bus(1'b0, mps_pkg::ADDR_STAT, 32'h0);
      chk("depth", q[17:16], 2'h0);
      $display("test return done");
      run('{28'h000_2010, 28'h010_2020, 28'h020_2030, 28'h030_1030,
         28'h040_3000, 28'h004_1004}, 60);
      bus(1'b0, mps_pkg::ADDR_STAT, 32'h0);
      chk("depth", q[17:16], 2'h2);
      chk("full", q[24], 1'b1);
      bus(1'b1, mps_pkg::ADDR_CTRL, 32'h3);
      int_request <= 1'b1;
      repeat (40) @(posedge clock);
      bus(1'b0, mps_pkg::ADDR_STAT, 32'h0);
      chk("pending", q[25], 1'b1);
      chk("held off", seen(12'h004), 1'b0);
      bus(1'b1, mps_pkg::ADDR_PC_LOW, 32'h40);
      repeat (60) @(posedge clock);
      chk("serviced", seen(12'h004), 1'b1);
      bus(1'b0, mps_pkg::ADDR_CTRL, 32'h0);
      chk("ien cleared", q[1:0], 2'h1);
      int_request <= 1'b0;
      $display("test stack done");
      close_out();
   end
endmodule : mps_sequencer_tb
